// ### design/icr_ctl_store.sv
`default_nettype none
module icr_ctl_store
   import icr_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic wr_en,
   input wire logic [63:0] wr_data,
   output logic priority_mask_hint_enable_q,
   output logic [4:0] mode_q
);
   // =========================================
   // Writable control bits
   // Hint enable reset
   always_ff @(posedge clk) begin
      if (rst) begin
         priority_mask_hint_enable_q <= CTL_PRIORITY_MASK_HINT_ENABLE_RESET;
      end else if (ce && wr_en) begin
         priority_mask_hint_enable_q <= wr_data[CTL_PRIORITY_MASK_HINT_ENABLE_POS];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         mode_q <= CTL_MODE_RESET;
      end else if (ce && wr_en) begin
         mode_q <= wr_data[4:0];
      end
   end
endmodule
`default_nettype wire

// ### design/icr_pkg.sv
`default_nettype none
package icr_pkg;
   localparam logic [1:0] EL0 = 2'h0;
   localparam logic [1:0] EL1 = 2'h1;
   localparam logic [1:0] EL2 = 2'h2;
   localparam logic [1:0] EL3 = 2'h3;
   // Encoding fields op0, op1, CRn, CRm, op2
   localparam logic [1:0] ENC_OP0 = 2'h3;
   localparam logic [3:0] ENC_CRN = 4'hC;
   localparam logic [2:0] VTR_OP1 = 3'h4;
   localparam logic [3:0] VTR_CRM = 4'hB;
   localparam logic [2:0] VTR_OP2 = 3'h1;
   localparam logic [2:0] CTL_OP1 = 3'h6;
   localparam logic [3:0] CTL_CRM = 4'hC;
   localparam logic [2:0] CTL_OP2 = 3'h4;
   // Type register fields
   localparam logic [2:0] VTR_PRIORITY_WIDTH = 3'h4;
   localparam logic [2:0] VTR_PREEMPTION_WIDTH = 3'h4;
   localparam logic [2:0] VTR_IDENTIFIER_WIDTH = 3'h0;
   localparam logic VTR_SYS_ERROR_IRQ_SUPPORT = 1'h0;
   localparam logic VTR_AFFINITY3_VALID = 1'h1;
   localparam logic VTR_NO_DIRECT_INJECTION = 1'h0;
   localparam logic VTR_DEACTIVATE_TRAP_SUPPORT = 1'h1;
   localparam logic VTR_DIRECT_VIRQ_MASK_SUPPORT = 1'h0;
   localparam logic [4:0] VTR_LIST_REGISTER_COUNT = 5'h03;
   localparam int VTR_PRI_POS = 29;
   localparam int VTR_PRE_POS = 26;
   localparam int VTR_ID_POS = 23;
   localparam int VTR_SYS_ERROR_IRQ_SUPPORT_POS = 22;
   localparam int VTR_A3_POS = 21;
   localparam int VTR_NDI_POS = 20;
   localparam int VTR_TDS_POS = 19;
   localparam int VTR_DVM_POS = 18;
   localparam int VTR_LR_POS = 0;
   // Control register fields
   localparam logic CTL_EXTENDED_ID_RANGE = 1'h1;
   localparam logic CTL_RANGE_SELECTOR_SUPPORT = 1'h0;
   localparam logic CTL_SECURITY_DISABLE_UNSUPPORTED = 1'h1;
   localparam logic CTL_AFFINITY3_VALID = 1'h1;
   localparam logic CTL_SYS_ERROR_IRQ_SUPPORT = 1'h0;
   localparam logic [2:0] CTL_IDENTIFIER_WIDTH = 3'h0;
   localparam logic [2:0] CTL_PRIORITY_WIDTH = 3'h4;
   localparam int CTL_EXT_POS = 19;
   localparam int CTL_RSS_POS = 18;
   localparam int CTL_NDS_POS = 17;
   localparam int CTL_A3_POS = 15;
   localparam int CTL_SYS_ERROR_IRQ_SUPPORT_POS = 14;
   localparam int CTL_ID_POS = 11;
   localparam int CTL_PRI_POS = 8;
   localparam int CTL_PRIORITY_MASK_HINT_ENABLE_POS = 6;
   localparam int CTL_EOI_NS_POS = 4;
   localparam int CTL_EOI_S_POS = 3;
   localparam int CTL_EOI_TOP_POS = 2;
   localparam int CTL_CBP_NS_POS = 1;
   localparam int CTL_CBP_S_POS = 0;
   localparam logic CTL_PRIORITY_MASK_HINT_ENABLE_RESET = 1'h0;
   // Writable mode bits reset to a defined zero
   localparam logic [4:0] CTL_MODE_RESET = 5'h00;
   typedef enum logic [1:0] {
      ICR_IDLE = 2'b00,
      ICR_DONE = 2'b01,
      ICR_FAULT = 2'b11
   } icr_state_t;
endpackage
`default_nettype wire

// ### design/icr_regs.sv
`default_nettype none
module icr_regs
   import icr_pkg::*;
(
   input wire logic MCLK,
   input wire logic SRST,
   input wire logic CE,
   input wire logic EL2_PRESENT,
   input wire logic REQ,
   input wire logic REQ_WRITE,
   input wire logic [1:0] REQ_EL,
   input wire logic [1:0] REQ_OP0,
   input wire logic [2:0] REQ_OP1,
   input wire logic [3:0] REQ_CRN,
   input wire logic [3:0] REQ_CRM,
   input wire logic [2:0] REQ_OP2,
   input wire logic [63:0] REQ_WDATA,
   output logic ACK,
   output logic UNDEF,
   output logic [63:0] RDATA,
   output logic PRIORITY_MASK_HINT_ENABLE,
   output logic EOI_MODE_NONSECURE_LOW,
   output logic EOI_MODE_SECURE_LOW,
   output logic EOI_MODE_TOP,
   output logic COMMON_BINPOINT_NONSECURE,
   output logic COMMON_BINPOINT_SECURE
);
   logic hit_vtr;
   logic hit_ctl;
   logic vtr_ok;
   logic ctl_ok;
   logic ctl_wr;
   logic priority_mask_hint_enable_q;
   logic [4:0] mode_q;
   logic [63:0] vtr_val;
   logic [63:0] ctl_val;
   logic [63:0] rdata_d;
   logic undef_d;
   icr_state_t state_q;

   // =========================================
   // Decode
   assign hit_vtr = (REQ_OP0 == ENC_OP0) && (REQ_OP1 == VTR_OP1) && (REQ_CRN == ENC_CRN)
                    && (REQ_CRM == VTR_CRM) && (REQ_OP2 == VTR_OP2);
   assign hit_ctl = (REQ_OP0 == ENC_OP0) && (REQ_OP1 == CTL_OP1) && (REQ_CRN == ENC_CRN)
                    && (REQ_CRM == CTL_CRM) && (REQ_OP2 == CTL_OP2);
   // Type register read only from levels 2 and 3; control register read and write from level 3 only
   assign vtr_ok = hit_vtr && !REQ_WRITE && ((REQ_EL == EL2) || (REQ_EL == EL3));
   assign ctl_ok = hit_ctl && (REQ_EL == EL3);
   assign ctl_wr = REQ && ctl_ok && REQ_WRITE;

   icr_ctl_store u_store (
      .clk(MCLK),
      .rst(SRST),
      .ce(CE),
      .wr_en(ctl_wr),
      .wr_data(REQ_WDATA),
      .priority_mask_hint_enable_q(priority_mask_hint_enable_q),
      .mode_q(mode_q)
   );

   // =========================================
   // Read values
   always_comb begin
      vtr_val = 64'h0000000000000000;
      if (EL2_PRESENT) begin
         vtr_val[VTR_PRI_POS +: 3] = VTR_PRIORITY_WIDTH;
         vtr_val[VTR_PRE_POS +: 3] = VTR_PREEMPTION_WIDTH;
         vtr_val[VTR_ID_POS +: 3] = VTR_IDENTIFIER_WIDTH;
         vtr_val[VTR_SYS_ERROR_IRQ_SUPPORT_POS] = VTR_SYS_ERROR_IRQ_SUPPORT;
         vtr_val[VTR_A3_POS] = VTR_AFFINITY3_VALID;
         vtr_val[VTR_NDI_POS] = VTR_NO_DIRECT_INJECTION;
         vtr_val[VTR_TDS_POS] = VTR_DEACTIVATE_TRAP_SUPPORT;
         vtr_val[VTR_DVM_POS] = VTR_DIRECT_VIRQ_MASK_SUPPORT;
         vtr_val[VTR_LR_POS +: 5] = VTR_LIST_REGISTER_COUNT;
      end else begin
         vtr_val[VTR_NDI_POS] = 1'h1;
      end
   end

   always_comb begin
      ctl_val = 64'h0000000000000000;
      ctl_val[CTL_EXT_POS] = CTL_EXTENDED_ID_RANGE;
      ctl_val[CTL_RSS_POS] = CTL_RANGE_SELECTOR_SUPPORT;
      ctl_val[CTL_NDS_POS] = CTL_SECURITY_DISABLE_UNSUPPORTED;
      ctl_val[CTL_A3_POS] = CTL_AFFINITY3_VALID;
      ctl_val[CTL_SYS_ERROR_IRQ_SUPPORT_POS] = CTL_SYS_ERROR_IRQ_SUPPORT;
      ctl_val[CTL_ID_POS +: 3] = CTL_IDENTIFIER_WIDTH;
      ctl_val[CTL_PRI_POS +: 3] = CTL_PRIORITY_WIDTH;
      ctl_val[CTL_PRIORITY_MASK_HINT_ENABLE_POS] = priority_mask_hint_enable_q;
      ctl_val[4:0] = mode_q;
   end

   always_comb begin
      rdata_d = 64'h0000000000000000;
      undef_d = 1'b0;
      if (vtr_ok) begin
         rdata_d = vtr_val;
      end else if (ctl_ok && !REQ_WRITE) begin
         rdata_d = ctl_val;
      end else if (!ctl_ok) begin
         undef_d = 1'b1;
      end
   end

   // =========================================
   // Answer, one cycle after the request
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         state_q <= ICR_IDLE;
      end else if (CE) begin
         if (REQ) begin
            state_q <= undef_d ? ICR_FAULT : ICR_DONE;
         end else begin
            state_q <= ICR_IDLE;
         end
      end
   end

   always_ff @(posedge MCLK) begin
      if (SRST) begin
         ACK <= 1'b0;
         UNDEF <= 1'b0;
         RDATA <= 64'h0000000000000000;
      end else if (CE) begin
         ACK <= REQ;
         UNDEF <= REQ && undef_d;
         RDATA <= REQ ? rdata_d : 64'h0000000000000000;
      end
   end

   // Mode outputs are registered copies of the store flops, one cycle behind
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         PRIORITY_MASK_HINT_ENABLE <= CTL_PRIORITY_MASK_HINT_ENABLE_RESET;
         EOI_MODE_NONSECURE_LOW <= 1'b0;
         EOI_MODE_SECURE_LOW <= 1'b0;
         EOI_MODE_TOP <= 1'b0;
         COMMON_BINPOINT_NONSECURE <= 1'b0;
         COMMON_BINPOINT_SECURE <= 1'b0;
      end else if (CE) begin
         PRIORITY_MASK_HINT_ENABLE <= priority_mask_hint_enable_q;
         EOI_MODE_NONSECURE_LOW <= mode_q[CTL_EOI_NS_POS];
         EOI_MODE_SECURE_LOW <= mode_q[CTL_EOI_S_POS];
         EOI_MODE_TOP <= mode_q[CTL_EOI_TOP_POS];
         COMMON_BINPOINT_NONSECURE <= mode_q[CTL_CBP_NS_POS];
         COMMON_BINPOINT_SECURE <= mode_q[CTL_CBP_S_POS];
      end
   end
endmodule
`default_nettype wire

// ### tb/icr_core_model.sv
`default_nettype none
module icr_core_model
   import icr_pkg::*;
(
   input wire logic MCLK, ACK, UNDEF,
   input wire logic [63:0] RDATA,
   output logic REQ, REQ_WRITE,
   output logic [1:0] REQ_EL, REQ_OP0,
   output logic [2:0] REQ_OP1, REQ_OP2,
   output logic [3:0] REQ_CRN, REQ_CRM,
   output logic [63:0] REQ_WDATA
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      REQ = 1'b0;
      {REQ_WRITE, REQ_EL, REQ_OP0, REQ_OP1, REQ_CRN, REQ_CRM, REQ_OP2, REQ_WDATA} = '0;
   end
   // ==========================================
   // One access; sel 0 type, 1 control, 2 unmapped
   task automatic acc(input logic wr, input logic [1:0] el, input int sel, input logic [63:0] wd,
      output logic ak, output logic un, output logic [63:0] rd);
      @(negedge MCLK);
      REQ = 1'b1;
      REQ_WRITE = wr;
      REQ_EL = el;
      {REQ_OP0, REQ_OP1, REQ_CRN, REQ_CRM, REQ_OP2} = (sel == 0) ? {ENC_OP0, VTR_OP1, ENC_CRN, VTR_CRM, VTR_OP2}
         : {ENC_OP0, (sel == 1) ? CTL_OP1 : 3'h0, ENC_CRN, CTL_CRM, CTL_OP2};
      REQ_WDATA = wd;
      @(negedge MCLK);
      ak = ACK;
      un = UNDEF;
      rd = RDATA;
      REQ = 1'b0;
      // Flip released fields so stale values never pass for a request
      {REQ_WRITE, REQ_EL, REQ_OP1, REQ_CRM, REQ_WDATA} = ~{REQ_WRITE, REQ_EL, REQ_OP1, REQ_CRM, REQ_WDATA};
   endtask
endmodule
`default_nettype wire

// ### tb/icr_regs_checker.sv
`default_nettype none
module icr_regs_checker
   import icr_pkg::*;
(
   input wire logic MCLK, SRST, CE, EL2_PRESENT, REQ, REQ_WRITE, ACK, UNDEF, PRIORITY_MASK_HINT_ENABLE,
   input wire logic EOI_MODE_NONSECURE_LOW, EOI_MODE_SECURE_LOW, EOI_MODE_TOP,
   input wire logic COMMON_BINPOINT_NONSECURE, COMMON_BINPOINT_SECURE,
   input wire logic [1:0] REQ_EL, REQ_OP0,
   input wire logic [2:0] REQ_OP1, REQ_OP2,
   input wire logic [3:0] REQ_CRN, REQ_CRM,
   input wire logic [63:0] REQ_WDATA, RDATA
);
   // ==========================================
   // Decode
   wire logic tk = REQ && CE;
   wire logic vtr = {REQ_OP0, REQ_OP1, REQ_CRN, REQ_CRM, REQ_OP2} == {ENC_OP0, VTR_OP1, ENC_CRN, VTR_CRM, VTR_OP2};
   wire logic ctl = {REQ_OP0, REQ_OP1, REQ_CRN, REQ_CRM, REQ_OP2} == {ENC_OP0, CTL_OP1, ENC_CRN, CTL_CRM, CTL_OP2};
   wire logic [5:0] mode = {PRIORITY_MASK_HINT_ENABLE, EOI_MODE_NONSECURE_LOW, EOI_MODE_SECURE_LOW, EOI_MODE_TOP,
      COMMON_BINPOINT_NONSECURE, COMMON_BINPOINT_SECURE};
   default clocking @(posedge MCLK); endclocking
   default disable iff (SRST);
   a_ack_after_req: assert property (tk |=> ACK)
      else $error("no answer after request");
   a_undef_low_level: assert property (tk && REQ_EL < EL2 |=> UNDEF && RDATA == 64'h0)
      else $error("low level access not refused");
   a_type_value: assert property (tk && vtr && !REQ_WRITE && REQ_EL >= EL2 && EL2_PRESENT
      |=> !UNDEF && RDATA == 64'h0000_0000_9028_0003) else $error("type register value wrong");
   a_type_no_el2: assert property (tk && vtr && !REQ_WRITE && REQ_EL == EL3 && !EL2_PRESENT
      |=> RDATA == 64'h0000_0000_0010_0000) else $error("type value without level 2 wrong");
   a_type_write: assert property (tk && vtr && REQ_WRITE |=> UNDEF)
      else $error("type register write accepted");
   a_ctl_level: assert property (tk && ctl && REQ_EL != EL3 |=> UNDEF)
      else $error("control access below level 3 accepted");
   a_ctl_fixed: assert property (tk && ctl && !REQ_WRITE && REQ_EL == EL3
      |=> !UNDEF && (RDATA & 64'hFFFF_FFFF_FFFF_FFA0) == 64'h000A_8400) else $error("control fixed bits wrong");
   a_mode_follow: assert property ((tk && ctl && REQ_WRITE && REQ_EL == EL3) ##1 CE
      |=> mode == {$past(REQ_WDATA[6], 2), $past(REQ_WDATA[4:0], 2)}) else $error("mode outputs wrong");
   a_undef_quiet: assert property (UNDEF |-> ACK && RDATA == 64'h0)
      else $error("refused access returned data");
   a_reset_clear: assert property (disable iff (1'b0) SRST && CE |=> !ACK && mode == 6'h00)
      else $error("outputs not cleared by reset");
endmodule
bind icr_regs icr_regs_checker u_chk (.*);
`default_nettype wire

// ### tb/icr_regs_tb.sv
`default_nettype none
module icr_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import icr_pkg::*;
   logic MCLK = 1'b0, SRST = 1'b1, CE = 1'b1, EL2_PRESENT = 1'b1;
   logic REQ, REQ_WRITE, ACK, UNDEF, PRIORITY_MASK_HINT_ENABLE, EOI_MODE_NONSECURE_LOW, EOI_MODE_SECURE_LOW, EOI_MODE_TOP;
   logic COMMON_BINPOINT_NONSECURE, COMMON_BINPOINT_SECURE, ak, un;
   logic [1:0] REQ_EL, REQ_OP0;
   logic [2:0] REQ_OP1, REQ_OP2;
   logic [3:0] REQ_CRN, REQ_CRM;
   logic [63:0] REQ_WDATA, RDATA, rd;
   int n_fail = 0, check_count = 0;
   always #4 MCLK = ~MCLK;
   icr_regs u_dut (.*);
   icr_core_model u_core (.*);
   // ==========================================
   // Helpers
   task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, got);
      end
   endtask
   function automatic logic [63:0] modes();
      return {57'h0, PRIORITY_MASK_HINT_ENABLE, 1'b0, EOI_MODE_NONSECURE_LOW, EOI_MODE_SECURE_LOW, EOI_MODE_TOP,
         COMMON_BINPOINT_NONSECURE, COMMON_BINPOINT_SECURE};
   endfunction
   task automatic acc(input logic w, input logic [1:0] el, input int sel, input logic [63:0] d);
      u_core.acc(w, el, sel, d, ak, un, rd);
      chk("ack", {63'h0, ak}, 64'h1);
   endtask
   task automatic results();
      $display("checks %0d, mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // ==========================================
   // Scenarios
   task automatic t_type();
      for (int i = 0; i < 4; i++) begin
         acc(1'b0, 2'(i), 0, 64'h0);
         chk("type read", rd, (i < 2) ? 64'h0 : 64'h0000_0000_9028_0003);
         chk("type undef", {63'h0, un}, (i < 2) ? 64'h1 : 64'h0);
      end
      acc(1'b1, EL3, 0, 64'hFFFF_FFFF_FFFF_FFFF);
      chk("type write", {63'h0, un}, 64'h1);
      EL2_PRESENT = 1'b0;
      acc(1'b0, EL3, 0, 64'h0);
      chk("type no level 2", rd, 64'h0000_0000_0010_0000);
      EL2_PRESENT = 1'b1;
      $display("type test done");
   endtask
   task automatic t_ctl();
      logic [63:0] d;
      acc(1'b0, EL3, 1, 64'h0);
      chk("ctl reset", rd, 64'h0000_0000_000A_8400);
      for (int i = 0; i < 7; i++) begin
         d = (i == 6) ? 64'hFFFF_FFFF_FFFF_FFFF : 64'h1 << ((i == 5) ? 6 : i);
         acc(1'b1, EL3, 1, d);
         acc(1'b0, EL3, 1, 64'h0);
         chk("ctl read", rd, 64'h0000_0000_000A_8400 | (d & 64'h5F));
         chk("mode out", modes(), d & 64'h5F);
      end
      $display("control test done");
   endtask
   task automatic t_undef();
      for (int i = 0; i < 4; i++) begin
         acc(1'b1, 2'(i), (i == 3) ? 2 : 1, 64'h0);
         chk("ctl undef", {63'h0, un}, 64'h1);
      end
      acc(1'b0, EL2, 1, 64'h0);
      chk("ctl level 2 read", {63'h0, un}, 64'h1);
      acc(1'b0, EL3, 1, 64'h0);
      chk("state kept", rd, 64'h0000_0000_000A_845F);
      chk("mode kept", modes(), 64'h5F);
      $display("refusal test done");
   endtask
   // Enable low must freeze the store; a mid-run reset must restore defaults
   task automatic t_hold();
      @(negedge MCLK);
      CE = 1'b0;
      u_core.acc(1'b1, EL3, 1, 64'h0, ak, un, rd);
      chk("frozen ack", {63'h0, ak}, 64'h0);
      CE = 1'b1;
      acc(1'b0, EL3, 1, 64'h0);
      chk("frozen ctl", rd, 64'h0000_0000_000A_845F);
      chk("frozen mode", modes(), 64'h5F);
      SRST = 1'b1;
      @(negedge MCLK);
      SRST = 1'b0;
      chk("reset mode", modes(), 64'h0);
      acc(1'b0, EL3, 1, 64'h0);
      chk("reset ctl", rd, 64'h0000_0000_000A_8400);
      $display("hold test done");
   endtask
   initial begin
      repeat (3) @(negedge MCLK);
      SRST = 1'b0;
      t_type();
      t_ctl();
      t_undef();
      t_hold();
      results();
   end
   // Some thirty two-cycle accesses; wide margin
   initial begin
      #(8 * 2000);
      n_fail++;
      $display("watchdog expired");
      results();
   end
endmodule
`default_nettype wire
